// ---- design/ltd_pkg.sv ----
// Package of constants and carrier types for the link training debug status block
package ltd_pkg;

    localparam int LANES = 8;
    localparam int FILL_W = 3;
    localparam int PARAM_W = 16;

    // Training state codes that matter here
    localparam logic [4:0] ST_CFG_IDLE = 5'h0b;
    localparam logic [4:0] ST_REC_IDLE = 5'h0e;

    // Idle symbols needed for a run
    localparam logic [3:0] IDLE_RUN_LEN = 4'h8;

    // One-hot lane width codes
    localparam logic [3:0] WIDTH_X1 = 4'h1;
    localparam logic [3:0] WIDTH_X2 = 4'h2;
    localparam logic [3:0] WIDTH_X4 = 4'h4;
    localparam logic [3:0] WIDTH_X8 = 4'h8;

    // APB byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT_LO = 8'h04;
    localparam logic [7:0] OFS_STAT_MID = 8'h08;
    localparam logic [7:0] OFS_STAT_HI = 8'h0c;
    localparam logic [7:0] OFS_ERR = 8'h10;

    // Control register fields and reset values
    localparam int CTRL_LANE0_LSB = 0;
    localparam int CTRL_LANE0_W = 3;
    localparam logic [2:0] CTRL_LANE0_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic [LANES-1:0] valid;
        logic [LANES-1:0] is_idle_data;
    } ltd_sym_type;

    typedef struct packed {
        logic [LANES-1:0] valid;
        logic [LANES-1:0] link_pad;
        logic [LANES-1:0] lane_pad;
        logic [LANES-1:0][PARAM_W-1:0] param;
    } ltd_ts_type;

    typedef struct packed {
        logic [LANES-1:0] push;
        logic [LANES-1:0] pop;
    } ltd_dsk_type;

    // Debug status bits 127 down to 48
    typedef struct packed {
        logic [LANES-1:0] deskew_err;
        logic [LANES-1:0][FILL_W-1:0] deskew_fill;
        logic [3:0] reserved;
        logic [3:0] lane_width;
        logic [7:0] ts_same_count;
        logic [LANES-1:0] lane_pad_seen;
        logic [LANES-1:0] link_pad_seen;
        logic [LANES-1:0] idle_run_alt;
        logic [LANES-1:0] idle_symbol_run_seen;
    } ltd_dbg_type;

endpackage

// ---- design/ltd_debug_status.sv ----
// Debug status bits 127:48 of an eight-lane link core, with APB register view
`timescale 1ns/10ps
module ltd_debug_status
    import ltd_pkg::*;
#(
    parameter int FIFO_DEPTH = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Link core side
    input wire logic [4:0] train_state,
    input wire logic [1:0] width_log2,
    input wire ltd_sym_type sym_in,
    input wire ltd_ts_type ts_in,
    input wire ltd_dsk_type dsk_in,
    output ltd_dbg_type debug_status,
    output logic rx_port_err,
    output logic retrain_req,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    if (FIFO_DEPTH < 1 || FIFO_DEPTH > (1 << FILL_W) - 1) begin : g_bad_depth
        $error("FIFO_DEPTH must fit the three-bit fill count");
    end

    localparam logic [FILL_W-1:0] FILL_MAX = FILL_W'(FIFO_DEPTH);

    function automatic logic [FILL_W-1:0] fill_next(
        input logic [FILL_W-1:0] fill,
        input logic push,
        input logic pop
    );
        logic [FILL_W-1:0] res;
        res = fill;
        if (push && !pop && fill != FILL_MAX) begin
            res = fill + FILL_W'(1);
        end else if (pop && !push && fill != '0) begin
            res = fill - FILL_W'(1);
        end
        return res;
    endfunction

    // State tracking
    logic [4:0] state_q;
    logic state_seen_q;
    wire state_change = state_seen_q && (train_state != state_q);
    wire in_idle_state = (train_state == ST_CFG_IDLE) || (train_state == ST_REC_IDLE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
            state_seen_q <= 1'b0;
        end else if (ce) begin
            state_q <= train_state;
            state_seen_q <= 1'b1;
        end
    end

    // Software control
    logic [CTRL_LANE0_W-1:0] lane0_sel_q;

    // Idle symbol runs per lane
    logic [LANES-1:0][3:0] run_q;
    logic [LANES-1:0][3:0] run_d;
    logic [LANES-1:0] idle_seen_q;
    logic [LANES-1:0] idle_seen_d;

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            run_d[i] = run_q[i];
            idle_seen_d[i] = idle_seen_q[i];
            if (!in_idle_state || state_change) begin
                run_d[i] = '0;
                idle_seen_d[i] = 1'b0;
            end else if (sym_in.valid[i]) begin
                if (!sym_in.is_idle_data[i]) begin
                    run_d[i] = '0;
                end else if (run_q[i] != IDLE_RUN_LEN) begin
                    run_d[i] = run_q[i] + 4'h1;
                end
                if (sym_in.is_idle_data[i] && run_q[i] == IDLE_RUN_LEN - 4'h1) begin
                    idle_seen_d[i] = 1'b1;
                end
            end
        end
    end

    // PAD detection per lane
    wire [LANES-1:0] link_pad_hit = ts_in.valid & ts_in.link_pad;
    wire [LANES-1:0] lane_pad_hit = ts_in.valid & ts_in.lane_pad;
    logic [LANES-1:0] link_pad_q;
    logic [LANES-1:0] lane_pad_q;
    wire [LANES-1:0] link_pad_d = state_change ? '0 : (link_pad_q | link_pad_hit);
    wire [LANES-1:0] lane_pad_d = state_change ? '0 : (lane_pad_q | lane_pad_hit);

    // Identical TS count on logical lane zero
    wire lane0_ts = ts_in.valid[lane0_sel_q];
    wire [PARAM_W-1:0] lane0_param = ts_in.param[lane0_sel_q];
    logic [PARAM_W-1:0] last_param_q;
    logic last_valid_q;
    logic [7:0] ts_count_q;
    wire ts_same = last_valid_q && (lane0_param == last_param_q);
    wire [7:0] ts_count_d = state_change ? 8'h00 :
                            !lane0_ts ? ts_count_q :
                            ts_same ? ts_count_q + 8'h01 : 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_param_q <= '0;
            last_valid_q <= 1'b0;
        end else if (ce) begin
            if (state_change) begin
                last_valid_q <= 1'b0;
            end else if (lane0_ts) begin
                last_param_q <= lane0_param;
                last_valid_q <= 1'b1;
            end
        end
    end

    // Lane width one-hot
    wire [3:0] width_onehot = (width_log2 == 2'h0) ? WIDTH_X1 :
                              (width_log2 == 2'h1) ? WIDTH_X2 :
                              (width_log2 == 2'h2) ? WIDTH_X4 : WIDTH_X8;

    // Deskew fill and overflow
    logic [LANES-1:0][FILL_W-1:0] fill_q;
    logic [LANES-1:0][FILL_W-1:0] fill_d;
    logic [LANES-1:0] ovf_hit;

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            fill_d[i] = fill_next(fill_q[i], dsk_in.push[i], dsk_in.pop[i]);
            ovf_hit[i] = dsk_in.push[i] && !dsk_in.pop[i] && fill_q[i] == FILL_MAX;
        end
    end

    logic [LANES-1:0] err_q;
    logic [LANES-1:0] err_clr;
    wire [LANES-1:0] err_d = (err_q & ~err_clr) | ovf_hit;

    // Idle run counters and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= '0;
            idle_seen_q <= '0;
        end else if (ce) begin
            run_q <= run_d;
            idle_seen_q <= idle_seen_d;
        end
    end

    // Sticky PAD flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_pad_q <= '0;
            lane_pad_q <= '0;
        end else if (ce) begin
            link_pad_q <= link_pad_d;
            lane_pad_q <= lane_pad_d;
        end
    end

    // Identical TS count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ts_count_q <= '0;
        end else if (ce) begin
            ts_count_q <= ts_count_d;
        end
    end

    // Deskew fill and sticky overflow flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_q <= '0;
            err_q <= '0;
        end else if (ce) begin
            fill_q <= fill_d;
            err_q <= err_d;
        end
    end

    // Per physical lane fill views
    wire [FILL_W-1:0] deskew_fill_lane_zero = fill_d[0];
    wire [FILL_W-1:0] deskew_fill_lane_one = fill_d[1];
    wire [FILL_W-1:0] deskew_fill_lane_two = fill_d[2];
    wire [FILL_W-1:0] deskew_fill_lane_three = fill_d[3];
    wire [FILL_W-1:0] deskew_fill_lane_four = fill_d[4];
    wire [FILL_W-1:0] deskew_fill_lane_five = fill_d[5];
    wire [FILL_W-1:0] deskew_fill_lane_six = fill_d[6];
    wire [FILL_W-1:0] deskew_fill_lane_seven = fill_d[7];

    // Status output image
    ltd_dbg_type dbg_d;
    always_comb begin
        dbg_d.deskew_err = err_d;
        dbg_d.deskew_fill = {deskew_fill_lane_seven, deskew_fill_lane_six,
            deskew_fill_lane_five, deskew_fill_lane_four, deskew_fill_lane_three,
            deskew_fill_lane_two, deskew_fill_lane_one, deskew_fill_lane_zero};
        dbg_d.reserved = 4'h0;
        dbg_d.lane_width = width_onehot;
        dbg_d.ts_same_count = ts_count_d;
        dbg_d.lane_pad_seen = lane_pad_d;
        dbg_d.link_pad_seen = link_pad_d;
        dbg_d.idle_run_alt = idle_seen_d;
        dbg_d.idle_symbol_run_seen = idle_seen_d;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_status <= '{lane_width: WIDTH_X1, default: '0};
        end else if (ce) begin
            debug_status <= dbg_d;
        end
    end

    // One-cycle error and retrain pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_port_err <= 1'b0;
            retrain_req <= 1'b0;
        end else if (ce) begin
            rx_port_err <= |ovf_hit;
            retrain_req <= |ovf_hit;
        end
    end

    // APB decode
    wire setup = psel && !penable;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_lo = paddr == OFS_STAT_LO;
    wire hit_mid = paddr == OFS_STAT_MID;
    wire hit_hi = paddr == OFS_STAT_HI;
    wire hit_err = paddr == OFS_ERR;
    wire hit_any = hit_ctrl | hit_lo | hit_mid | hit_hi | hit_err;
    wire access_done = psel && penable && pready;
    wire wr_done = access_done && pwrite && !pslverr;
    wire [79:0] dbg_bits = debug_status;

    assign err_clr = (wr_done && hit_err) ? pwdata[LANES-1:0] : '0;

    // Read words, upper status word padded with zero
    wire [31:0] rd_ctrl = {29'h0, lane0_sel_q};
    wire [31:0] rd_lo = dbg_bits[31:0];
    wire [31:0] rd_mid = dbg_bits[63:32];
    wire [31:0] rd_hi = {16'h0, dbg_bits[79:64]};
    wire [31:0] rd_err = {24'h0, err_q};

    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                         hit_lo ? rd_lo :
                         hit_mid ? rd_mid :
                         hit_hi ? rd_hi :
                         hit_err ? rd_err : RDATA_RST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RDATA_RST;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && !hit_any;
            prdata <= (setup && !pwrite) ? rd_mux : RDATA_RST;
        end
    end

    // Logical lane zero select, written at the access edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lane0_sel_q <= CTRL_LANE0_RST;
        end else if (ce) begin
            if (wr_done && hit_ctrl) begin
                lane0_sel_q <= pwdata[CTRL_LANE0_LSB +: CTRL_LANE0_W];
            end
        end
    end

endmodule

// ---- sim/ltd_debug_status_properties.sv ----
// Port assertions for the link training debug status block
`timescale 1ns/10ps
module ltd_debug_status_properties
    import ltd_pkg::*;
#(
    parameter int FIFO_DEPTH = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [4:0] train_state,
    input wire logic [1:0] width_log2,
    input wire ltd_ts_type ts_in,
    input wire ltd_dsk_type dsk_in,
    input wire ltd_dbg_type debug_status,
    input wire logic rx_port_err,
    input wire logic retrain_req,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready
);
    logic [7:0] full, ovf, lk, ln;
    always_comb for (int i = 0; i < 8; i++) full[i] = debug_status.deskew_fill[i] == FIFO_DEPTH;
    assign ovf = dsk_in.push & ~dsk_in.pop & full & {8{ce}};
    assign lk = ts_in.valid & ts_in.link_pad;
    assign ln = ts_in.valid & ts_in.lane_pad;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup; psel && !penable && ce; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_apb; s_setup |=> s_access; endproperty
    a_apb: assert property (p_apb) else $error("no ready after setup");
    property p_width;
        $past(ce) && !$past(rst) |-> debug_status.lane_width == 4'h1 << $past(width_log2);
    endproperty
    a_width: assert property (p_width) else $error("lane width code wrong");
    property p_rsvd; debug_status.reserved == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_copy; debug_status.idle_run_alt == debug_status.idle_symbol_run_seen; endproperty
    a_copy: assert property (p_copy) else $error("idle fields differ");
    property p_idle_off;
        $past(ce) && !$past(rst) && !$past(train_state == ST_CFG_IDLE || train_state == ST_REC_IDLE)
            |-> debug_status.idle_symbol_run_seen == 8'h0;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("idle flag outside idle");
    property p_pad;
        ce && $stable(train_state) |=> (debug_status.link_pad_seen & $past(lk)) == $past(lk)
            && (debug_status.lane_pad_seen & $past(ln)) == $past(ln);
    endproperty
    a_pad: assert property (p_pad) else $error("pad flag missed");
    property p_clear;
        ce && $past(ce) && !$past(rst) && !$past(rst, 2) && $changed(train_state)
            && ts_in.valid == 8'h0 |=> debug_status.ts_same_count == 8'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("count kept over state change");
    property p_ovf;
        ovf != 8'h0 |=> rx_port_err && (debug_status.deskew_err & $past(ovf)) == $past(ovf);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");
    property p_err_src; $past(ce) && rx_port_err |-> $past(ovf) != 8'h0 && retrain_req; endproperty
    a_err_src: assert property (p_err_src) else $error("stray port error");
    property p_fill;
        ce && dsk_in.push[2] && !dsk_in.pop[2] && !full[2]
            |=> debug_status.deskew_fill[2] == $past(debug_status.deskew_fill[2]) + 3'h1;
    endproperty
    a_fill: assert property (p_fill) else $error("fill not counted");
endmodule

// ---- sim/ltd_observer.sv ----
// Observer model of the logic that watches the debug status bus
`timescale 1ns/10ps
module ltd_observer
    import ltd_pkg::*;
(
    input wire logic [4:0] train_state,
    input wire ltd_dbg_type debug_status,
    output logic [7:0] idle_view
);
    wire in_idle = train_state == ST_CFG_IDLE || train_state == ST_REC_IDLE;
    assign idle_view = in_idle ? debug_status.idle_symbol_run_seen : 8'h0;
endmodule

// ---- sim/ltd_debug_status_tb.sv ----
// Self-checking testbench for the link training debug status block
`timescale 1ns/10ps
module ltd_debug_status_tb;
    import ltd_pkg::*;
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [4:0] train_state = '0;
    logic [1:0] width_log2 = '0;
    logic [7:0] paddr = '0, m, lk, ln, idle_view;
    logic [31:0] pwdata = '0, prdata;
    logic rx_port_err, retrain_req, pready, pslverr;
    ltd_sym_type sym_in = '0;
    ltd_ts_type ts_in = '0;
    ltd_dsk_type dsk_in = '0;
    ltd_dbg_type debug_status;
    logic [32:0] q[$];
    int mismatches = 0, n_checks = 0, seed = 32'h9db6;
    ltd_debug_status #(.FIFO_DEPTH(7)) dut (.clk, .rst, .ce, .train_state, .width_log2, .sym_in,
        .ts_in, .dsk_in, .debug_status, .rx_port_err, .retrain_req, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    ltd_observer obs (.train_state, .debug_status, .idle_view);
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic pulse(input ltd_sym_type s, input ltd_ts_type t, input ltd_dsk_type k);
        sym_in <= s;
        ts_in <= t;
        dsk_in <= k;
        @(posedge clk);
        sym_in <= '0;
        ts_in <= '0;
        dsk_in <= '0;
        @(posedge clk);
    endtask
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(e);
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk);
        while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic go(input logic [4:0] s);
        train_state <= s;
        repeat (3) @(posedge clk);
    endtask
    function automatic ltd_ts_type tsv(logic [7:0] v, logic [15:0] p);
        return '{v, 8'h0, 8'h0, {8{p}}};
    endfunction
    // Read answers are compared in the order they were requested
    always @(posedge clk) if (pready === 1'h1 && pwrite === 1'h0) chk({pslverr, prdata}, q.pop_front());
    initial begin
        #20000;
        mismatches++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk(debug_status, 80'h1 << 40);
        for (int w = 0; w < 4; w++) begin
            width_log2 <= 2'(w);
            repeat (2) @(posedge clk);
            chk(debug_status.lane_width, 4'h1 << w);
        end
        for (int s = 0; s < 3; s++) begin
            go(s == 0 ? ST_CFG_IDLE : s == 1 ? ST_REC_IDLE : 5'h0f);
            m = $random(seed);
            for (int i = 0; i < 8; i++) pulse('{8'hff, i == 3 ? m : 8'hff}, '0, '0);
            chk(debug_status.idle_symbol_run_seen, s == 2 ? 8'h0 : m);
            chk(debug_status.idle_run_alt, s == 2 ? 8'h0 : m);
            chk(idle_view, s == 2 ? 8'h0 : m);
        end
        go(5'h02);
        lk = $random(seed);
        ln = $random(seed);
        pulse('0, '{8'hff, lk, ln, {8{16'h1234}}}, '0);
        pulse('0, tsv(8'h01, 16'h1234), '0);
        pulse('0, tsv(8'h80, 16'h9999), '0);
        chk(debug_status.link_pad_seen, lk);
        chk(debug_status.lane_pad_seen, ln);
        chk(debug_status.ts_same_count, 8'h2);
        pulse('0, tsv(8'h01, 16'h5678), '0);
        chk(debug_status.ts_same_count, 8'h1);
        repeat (255) pulse('0, tsv(8'h01, 16'h5678), '0);
        chk(debug_status.ts_same_count, 8'h0);
        pulse('0, tsv(8'h01, 16'h5678), '0);
        go(5'h03);
        chk(debug_status[39:16], 24'h0);
        apb(1'h1, OFS_CTRL, 32'h3, '0);
        apb(1'h0, OFS_CTRL, '0, 33'h3);
        pulse('0, tsv(8'h08, 16'h1), '0);
        pulse('0, tsv(8'h01, 16'h2), '0);
        pulse('0, tsv(8'h08, 16'h1), '0);
        chk(debug_status.ts_same_count, 8'h2);
        for (int i = 0; i < 8; i++) pulse('0, '0, '{8'h04, 8'h00});
        chk({rx_port_err, retrain_req}, 2'h3);
        chk(debug_status.deskew_err, 8'h04);
        chk(debug_status.deskew_fill, 24'h7 << 6);
        pulse('0, '0, '{8'h00, 8'h04});
        chk({rx_port_err, debug_status.deskew_fill[2]}, 4'h6);
        apb(1'h0, OFS_STAT_MID, '0, 33'h0180_0802);
        apb(1'h0, OFS_ERR, '0, 33'h4);
        apb(1'h1, OFS_ERR, 32'h4, '0);
        apb(1'h0, OFS_ERR, '0, 33'h0);
        apb(1'h0, 8'h14, '0, 33'h1_0000_0000);
        chk(q.size(), 0);
        test_done;
    end
endmodule
bind ltd_debug_status ltd_debug_status_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk, .rst,
    .ce, .train_state, .width_log2, .ts_in, .dsk_in, .debug_status, .rx_port_err, .retrain_req,
    .psel, .penable, .pready);
